// *** co_defs.svh ***
`ifndef CO_DEFS_SVH
`define CO_DEFS_SVH
// register indices; byte address is four times the index
`define CO_IDX_TRX_CTRL0 8'h03
`define CO_IDX_OSC_CTRL 8'h12
`define CO_IDX_STATUS 8'h20
// reset values
`define CO_RST_RATE 3'h1
`define CO_RST_DEFER 1'b1
`define CO_RST_MODE 4'hf
`define CO_RST_TRIM 4'h0
// field codes
`define CO_MODE_EXT 4'h5
`define CO_RATE_OFF 3'h0
`define CO_RATE_16M 3'h5
// system clock and toggle-tick rate in MHz (toggle rate is twice the 16 MHz raw clock)
`define CO_SYS_MHZ 8'hc8
`define CO_TOG_MHZ 8'h20
// half periods in toggle ticks per rate code
`define CO_HALF_1M 9'h010
`define CO_HALF_2M 9'h008
`define CO_HALF_4M 9'h004
`define CO_HALF_8M 9'h002
`define CO_HALF_16M 9'h001
`define CO_HALF_250K 9'h040
`define CO_HALF_62K 9'h100
// extra output cycles before sleep
`define CO_DRAIN 6'h23
// bus responses
`define CO_RESP_OK 2'h0
`define CO_RESP_ERR 2'h2
`endif

// *** co_pkg.sv ***
`include "co_defs.svh"
package co_pkg;
	typedef enum logic [1:0] {CO_RUN, CO_DRAIN, CO_SLEEP, CO_WAKE} co_fsm_t;
	typedef struct packed {
		logic s1;
		logic s2;
		co_fsm_t st;
		logic deep;
		logic [7:0] acc;
		logic [8:0] cnt;
		logic out;
		logic [5:0] edges;
		logic [2:0] eff;
		logic [2:0] target;
		logic tom;
		logic pmu;
		logic pmuinv;
		logic defer;
		logic [2:0] rate;
		logic [3:0] mode;
		logic [3:0] trim;
		logic xosc_en;
		logic ext_ref;
		logic [3:0] trim_o;
		logic sleep_o;
		logic aw_got;
		logic w_got;
		logic [7:0] widx;
		logic [7:0] wd;
		logic wok;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
	} co_state_t;
	// half period of the output clock, in toggle ticks
	function automatic logic [8:0] co_half(input logic [2:0] rate);
		case (rate)
			3'h1: co_half = `CO_HALF_1M;
			3'h2: co_half = `CO_HALF_2M;
			3'h3: co_half = `CO_HALF_4M;
			3'h4: co_half = `CO_HALF_8M;
			3'h6: co_half = `CO_HALF_250K;
			3'h7: co_half = `CO_HALF_62K;
			default: co_half = `CO_HALF_16M;
		endcase
	endfunction
endpackage

// *** co_clkout.sv ***
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
// How it works
// - rate code 0 holds output low; 1-5 give 1..16 MHz; 6 250 kHz; 7 62.5 kHz.
// - with defer bit clear, a rate write takes effect at the next falling output edge (next tick when off), glitch free.
// - with defer set and old rate nonzero, new rate applies at next sleep exit.
// - reset keeps the running rate in a shadow; the field reads back 1.
// - after deepest sleep, output restarts at 1 MHz once the oscillator is stable.
// - fast rates emit 35 more output cycles before sleep is entered.
// - mode 0x5 selects external reference; 0xF enables oscillator; others reserved.
// - 4-bit load capacitance trim, all codes valid, resets to 0x0.
module co_clkout import co_pkg::*; #(
	parameter int ADDR_W = 10
) (
	// clock and resets
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// radio state inputs
	input wire logic sleep_control_pin,
	input wire logic radio_off_state,
	input wire logic deepest_low_power_state_req,
	input wire logic osc_stable,
	// clock output and oscillator controls
	output logic master_clock_out,
	output logic xosc_enable,
	output logic ext_ref_select,
	output logic [3:0] load_cap_trim,
	output logic sleep_active
);
	// refuse an address bus too narrow for the register index bits
	if (ADDR_W < 10) begin : g_addr_chk
		$error("ADDR_W too small for the register map");
	end

	co_state_t s_r;
	co_state_t s_nxt;
	logic [7:0] acc_sum;
	logic tick;
	logic tog;
	logic fast;
	logic [7:0] ridx;
	logic wfire;

	// next-state logic for the whole block
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = sleep_control_pin;
		s_nxt.s2 = s_r.s1;
		// fractional divider: one tick per output half period of the 16 MHz rate
		acc_sum = s_r.acc + `CO_TOG_MHZ;
		tick = 1'b0;
		if (acc_sum >= `CO_SYS_MHZ) begin
			tick = 1'b1;
			s_nxt.acc = acc_sum - `CO_SYS_MHZ;
		end else begin
			s_nxt.acc = acc_sum;
		end
		fast = (s_r.eff != `CO_RATE_OFF) && (s_r.eff <= `CO_RATE_16M);
		tog = tick && (s_r.st == CO_RUN || s_r.st == CO_DRAIN) && (s_r.eff != `CO_RATE_OFF)
			&& (s_r.cnt == co_half(s_r.eff) - 9'h001);
		// output divider; switches rate only with the output low
		if (s_r.st == CO_SLEEP || s_r.st == CO_WAKE) begin
			s_nxt.out = 1'b0;
			s_nxt.cnt = 9'h000;
		end else if (tick && s_r.eff == `CO_RATE_OFF) begin
			s_nxt.out = 1'b0;
			s_nxt.cnt = 9'h000;
			s_nxt.eff = s_r.target;
		end else if (tog) begin
			s_nxt.out = !s_r.out;
			s_nxt.cnt = 9'h000;
			if (s_r.out) begin
				s_nxt.eff = s_r.target;
			end
		end else if (tick) begin
			s_nxt.cnt = s_r.cnt + 9'h001;
		end
		// sleep sequencing
		case (s_r.st)
			CO_RUN: begin
				if (s_r.s2 && radio_off_state) begin
					s_nxt.st = CO_DRAIN;
					s_nxt.edges = 6'h00;
					s_nxt.deep = deepest_low_power_state_req;
				end
			end
			CO_DRAIN: begin
				if (fast) begin
					if (tog && s_r.out) begin
						s_nxt.edges = s_r.edges + 6'h01;
						if (s_r.edges == `CO_DRAIN - 6'h01) begin
							s_nxt.st = CO_SLEEP;
						end
					end
				end else if (!s_r.out) begin
					s_nxt.st = CO_SLEEP;
				end
			end
			CO_SLEEP: begin
				if (!s_r.s2) begin
					s_nxt.st = CO_WAKE;
				end
			end
			default: begin
				if (osc_stable) begin
					s_nxt.st = CO_RUN;
					s_nxt.target = s_r.deep ? `CO_RST_RATE : s_r.rate;
					s_nxt.eff = s_nxt.target;
				end
			end
		endcase
		// write channel capture, either order
		if (s_r.awready && awvalid) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.widx = awaddr[9:2];
		end
		if (s_r.wready && wvalid) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wd = wdata[7:0];
			s_nxt.wok = wstrb[0];
		end
		wfire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
		if (wfire) begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `CO_RESP_OK;
			if (s_r.widx == `CO_IDX_TRX_CTRL0) begin
				if (s_r.wok) begin
					s_nxt.tom = s_r.wd[7];
					s_nxt.pmu = s_r.wd[5];
					s_nxt.pmuinv = s_r.wd[4];
					s_nxt.defer = s_r.wd[3];
					s_nxt.rate = s_r.wd[2:0];
					if (!s_r.wd[3] || s_r.rate == `CO_RATE_OFF) begin
						s_nxt.target = s_r.wd[2:0];
					end
				end
			end else if (s_r.widx == `CO_IDX_OSC_CTRL) begin
				if (s_r.wok) begin
					s_nxt.mode = s_r.wd[7:4];
					s_nxt.trim = s_r.wd[3:0];
				end
			end else if (s_r.widx != `CO_IDX_STATUS) begin
				s_nxt.bresp = `CO_RESP_ERR;
			end
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
		end
		// read channel
		ridx = araddr[9:2];
		if (s_r.arready && arvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `CO_RESP_OK;
			if (ridx == `CO_IDX_TRX_CTRL0) begin
				s_nxt.rdata = {s_r.tom, 1'b0, s_r.pmu, s_r.pmuinv, s_r.defer, s_r.rate};
			end else if (ridx == `CO_IDX_OSC_CTRL) begin
				s_nxt.rdata = {s_r.mode, s_r.trim};
			end else if (ridx == `CO_IDX_STATUS) begin
				s_nxt.rdata = {1'b0, s_r.st == CO_WAKE, s_r.st == CO_DRAIN,
					s_r.st == CO_SLEEP, s_r.out, s_r.eff};
			end else begin
				s_nxt.rdata = 8'h00;
				s_nxt.rresp = `CO_RESP_ERR;
			end
		end
		if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
		// oscillator decode; reserved codes keep the oscillator running
		s_nxt.ext_ref = (s_r.mode == `CO_MODE_EXT);
		s_nxt.xosc_en = (s_r.mode != `CO_MODE_EXT);
		s_nxt.trim_o = s_r.trim;
		s_nxt.sleep_o = (s_nxt.st == CO_SLEEP);
		// block reset: running rate and divider survive it
		if (!aresetn) begin
			s_nxt.s1 = 1'b0;
			s_nxt.s2 = 1'b0;
			s_nxt.st = CO_RUN;
			s_nxt.deep = 1'b0;
			s_nxt.edges = 6'h00;
			s_nxt.tom = 1'b0;
			s_nxt.pmu = 1'b0;
			s_nxt.pmuinv = 1'b0;
			s_nxt.defer = `CO_RST_DEFER;
			s_nxt.rate = `CO_RST_RATE;
			s_nxt.mode = `CO_RST_MODE;
			s_nxt.trim = `CO_RST_TRIM;
			s_nxt.xosc_en = 1'b1;
			s_nxt.ext_ref = 1'b0;
			s_nxt.trim_o = `CO_RST_TRIM;
			s_nxt.sleep_o = 1'b0;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.widx = 8'h00;
			s_nxt.wd = 8'h00;
			s_nxt.wok = 1'b0;
			s_nxt.awready = 1'b0;
			s_nxt.wready = 1'b0;
			s_nxt.bvalid = 1'b0;
			s_nxt.bresp = `CO_RESP_OK;
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b0;
			s_nxt.rresp = `CO_RESP_OK;
			s_nxt.rdata = 8'h00;
		end
		// power-on clears the divider and sets the shadow rate back to 1
		if (!por_n) begin
			s_nxt.acc = 8'h00;
			s_nxt.cnt = 9'h000;
			s_nxt.out = 1'b0;
			s_nxt.eff = `CO_RST_RATE;
			s_nxt.target = `CO_RST_RATE;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		s_r <= s_nxt;
	end

	// outputs straight from the state flops
	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rresp = s_r.rresp;
	assign rdata = {24'h000000, s_r.rdata};
	assign master_clock_out = s_r.out;
	assign xosc_enable = s_r.xosc_en;
	assign ext_ref_select = s_r.ext_ref;
	assign load_cap_trim = s_r.trim_o;
	assign sleep_active = s_r.sleep_o;

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !por_n);
	sequence wake_deep_s;
		s_r.st == CO_WAKE && osc_stable && s_r.deep;
	endsequence
	sequence trx_write_s;
		wfire && s_r.widx == `CO_IDX_TRX_CTRL0 && s_r.wok;
	endsequence
	off_pin_low_a: assert property (s_r.eff == `CO_RATE_OFF |-> !s_r.out)
		else $error("output toggles while rate is off");
	toggle_on_tick_a: assert property ($changed(s_r.out) && s_r.st != CO_SLEEP |-> $past(tick))
		else $error("output changed off the tick");
	immed_rate_a: assert property (trx_write_s ##0 !s_r.wd[3] |=> s_r.target == $past(s_r.wd[2:0]))
		else $error("immediate rate not taken");
	defer_hold_a: assert property (trx_write_s ##0 s_r.wd[3] && s_r.rate != `CO_RATE_OFF
		&& s_r.st != CO_WAKE |=> $stable(s_r.target))
		else $error("deferred rate applied early");
	reset_shadow_a: assert property (@(posedge aclk) disable iff (!por_n)
		!aresetn |=> s_r.rate == `CO_RST_RATE && s_r.eff == $past(s_r.eff))
		else $error("reset lost shadow rate");
	deep_wake_a: assert property (wake_deep_s |=> s_r.st == CO_RUN && s_r.eff == `CO_RST_RATE)
		else $error("deep wake not at default rate");
	drain_count_a: assert property (s_r.st == CO_SLEEP && $past(s_r.st) == CO_DRAIN && $past(fast)
		|-> $past(s_r.edges) == `CO_DRAIN - 6'h01)
		else $error("wrong drain cycle count");
	mode_decode_a: assert property (##1 s_r.ext_ref == ($past(s_r.mode) == `CO_MODE_EXT)
		&& s_r.xosc_en == !s_r.ext_ref)
		else $error("oscillator mode decode wrong");
	trim_follow_a: assert property (##1 s_r.trim_o == $past(s_r.trim))
		else $error("trim output stale");
	no_runt_a: assert property ($changed(s_r.eff) |-> !s_r.out && s_r.cnt == 9'h000)
		else $error("rate switched mid pulse");
endmodule

// *** co_host_mon.sv ***
`timescale 1ns/10ps
// host side: times the divided clock and counts its edges
module co_host_mon (
	// system clock
	input wire logic aclk,
	// clock from the device
	input wire logic clk_in,
	// measurements
	output int per,
	output int rises,
	output int falls
);
	logic prev;
	int cnt;
	// start counts from zero
	initial begin
		prev = 1'h0;
		cnt = 0;
		per = 0;
		rises = 0;
		falls = 0;
	end
	// period between rising edges, in system cycles
	always @(posedge aclk) begin
		prev <= clk_in;
		cnt <= cnt + 1;
		if (clk_in && !prev) begin
			per <= cnt;
			cnt <= 1;
			rises <= rises + 1;
		end
		if (!clk_in && prev)
			falls <= falls + 1;
	end
endmodule

// *** test_co_clkout.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("[ERR] %0t got %0h want %0h", $time, a, b); end end
module test_co_clkout;
	logic aclk = 1'h0, aresetn = 1'h0, por_n = 1'h0;
	logic [9:0] awaddr = 10'h0, araddr = 10'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hf, load_cap_trim;
	logic sleep_control_pin = 1'h0, radio_off_state = 1'h1, deepest_low_power_state_req = 1'h0;
	logic osc_stable = 1'h1;
	logic awready, wready, bvalid, arready, rvalid, master_clock_out;
	logic xosc_enable, ext_ref_select, sleep_active;
	logic [1:0] bresp, rresp, resp;
	logic [7:0] d, q, t;
	int per, rises, falls, r0, f0, n, st, cyc = 0, seed = 69, miscompares = 0, checks = 0;
	int exp2[8] = '{0, 400, 200, 100, 50, 25, 1600, 6400};
	// device and host clock consumer
	co_clkout DUT (.aclk, .aresetn, .por_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .sleep_control_pin, .radio_off_state, .deepest_low_power_state_req,
		.osc_stable, .master_clock_out, .xosc_enable, .ext_ref_select, .load_cap_trim,
		.sleep_active);
	co_host_mon HOST (.aclk(aclk), .clk_in(master_clock_out), .per(per), .rises(rises),
		.falls(falls));
	// 200 mhz clock
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	task end_sim;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			end_sim;
		end
	end
	// one axi write, address and data offered together
	task wr(input logic [7:0] idx, input logic [7:0] v);
		@(posedge aclk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, v};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready === 1'h1) awvalid <= 1'h0;
			if (wready === 1'h1) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		resp = bresp;
		bready <= 1'h0;
	endtask
	// one axi read
	task rd(input logic [7:0] idx);
		@(posedge aclk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready === 1'h1) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		{resp, q} = {rresp, rdata[7:0]};
		rready <= 1'h0;
	endtask
	// period within jitter of the fractional divider, in half cycles
	function automatic logic near(int m, logic [2:0] c);
		near = (2 * m - exp2[c] <= 6) && (exp2[c] - 2 * m <= 6);
	endfunction
	// let the rate settle, then check the last full period
	task meas(input logic [2:0] c);
		r0 = rises;
		wait (rises >= r0 + 3);
		@(posedge aclk);
		`CHK(near(per, c), 1'h1)
	endtask
	// request sleep, count drain edges, wake with a slow oscillator
	task sleep_cycle(input logic dp);
		f0 = falls;
		sleep_control_pin <= 1'h1;
		deepest_low_power_state_req <= dp;
		do @(posedge aclk); while (sleep_active !== 1'h1);
		// one more edge so the host has counted the last drain fall
		@(posedge aclk);
		n = falls - f0;
		osc_stable <= 1'h0;
		sleep_control_pin <= 1'h0;
		repeat (40) @(posedge aclk);
		`CHK(master_clock_out, 1'h0)
		// status while waiting: wake flag set, output low, last rate still 16 MHz
		rd(8'h20);
		`CHK({resp, q}, {2'h0, 8'h45})
		osc_stable <= 1'h1;
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		por_n <= 1'h1;
		repeat (2) @(posedge aclk);
		rd(8'h03);
		`CHK({resp, q}, {2'h0, 8'h09})
		rd(8'h12);
		`CHK({resp, q}, {2'h0, 8'hf0})
		rd(8'h07);
		`CHK(resp, 2'h2)
		wr(8'h07, 8'h00);
		`CHK(resp, 2'h2)
		`CHK({xosc_enable, ext_ref_select, load_cap_trim}, 6'h20)
		$display("test reset done");
		t = {4'h5, 4'($random(seed))};
		wr(8'h12, t);
		repeat (2) @(posedge aclk);
		`CHK({xosc_enable, ext_ref_select, load_cap_trim}, {2'h1, t[3:0]})
		wr(8'h12, {4'ha, t[3:0]});
		repeat (2) @(posedge aclk);
		`CHK({xosc_enable, ext_ref_select}, 2'h2)
		wr(8'h12, 8'hf0);
		// a write with byte lane 0 disabled leaves the register alone
		wstrb <= 4'h0;
		wr(8'h12, 8'h5a);
		wstrb <= 4'hf;
		rd(8'h12);
		`CHK({resp, q}, {2'h0, 8'hf0})
		wr(8'h20, 8'hff);
		`CHK(resp, 2'h0)
		$display("test oscillator done");
		st = {$random(seed)} % 7;
		for (int i = 0; i < 7; i++) begin
			d = (8'($random(seed)) & 8'hb0) | 8'((st + i) % 7 + 1);
			wr(8'h03, d);
			rd(8'h03);
			`CHK(q, d)
			meas(d[2:0]);
		end
		wr(8'h03, 8'h00);
		// a slow old rate can take a full period to reach its falling edge
		repeat (3300) @(posedge aclk);
		r0 = rises;
		repeat (400) @(posedge aclk);
		`CHK({rises == r0, master_clock_out}, 2'h2)
		rd(8'h20);
		`CHK({resp, q}, {2'h0, 8'h00})
		$display("test rates done");
		wr(8'h03, 8'h0d);
		meas(3'h5);
		wr(8'h03, 8'h09);
		meas(3'h5);
		sleep_cycle(1'h0);
		`CHK(n >= 35 && n <= 36, 1'h1)
		meas(3'h1);
		$display("test defer done");
		wr(8'h03, 8'h05);
		meas(3'h5);
		aresetn <= 1'h0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		meas(3'h5);
		rd(8'h03);
		`CHK(q, 8'h09)
		sleep_cycle(1'h0);
		meas(3'h1);
		$display("test shadow done");
		wr(8'h03, 8'h05);
		meas(3'h5);
		sleep_cycle(1'h1);
		meas(3'h1);
		$display("test deep done");
		end_sim;
	end
endmodule
